// >>> dv/tb_top.sv
// Self-checking bench for the watchdog and reset controller.
module tb_top import wdr_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned LIM = 20;
  localparam int unsigned OSC = 40;
  localparam int unsigned XP  = 8;
  logic        clk = 1'h0, nrst = 1'h0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00, ice_cmd = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic        arvalid = 1'h0, rready = 1'h0, ice_cmd_valid = 1'h0;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0]  bresp, rresp;
  logic        xrun = 1'h1, ext_low = 1'h0, emu_low = 1'h0;
  logic        pf_below = 1'h0, pf_tied = 1'h0, wake = 1'h1;
  wdr_src_t    src;
  wdr_rst_t    rst;
  int          n_errors = 0, total_checks = 0, n_fall = 0, n_xtal = 0;
  int          m_flag = 0, m_int = 0, m_mask = 0;

  always #2.5 clk = ~clk;
  // Event counters used by the reference model.
  always @(negedge rst.mpu_reset_n) n_fall++;
  always @(posedge src.crystal_clock_32k) n_xtal++;

  wdr_src_model u_src (.xtal_run(xrun), .ext_low(ext_low), .emu_low(emu_low),
    .pf_below(pf_below), .pf_tied(pf_tied), .wake(wake), .src(src));
  wdr_watchdog #(.WDT_LIMIT(LIM), .OSC_TIMEOUT(OSC)) uut (
    .clk(clk), .nrst(nrst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .src(src), .ice_cmd_valid(ice_cmd_valid), .ice_cmd(ice_cmd), .rst(rst),
    .irq(irq));

  task automatic end_of_test();
    if (n_errors == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Bus write: address and data offered together, each dropped when taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'h0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'h0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'h0;
  endtask

  task automatic w(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, r);
    chk(32'(r), 32'(RESP_OKAY));
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] m,
                    input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk(32'(r), 32'(RESP_OKAY));
    chk(d & m, e);
  endtask

  task automatic ck_irq();
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'((m_int & m_mask) != 0));
  endtask

  // Waits for a processor reset, then times the pulse and the restart.
  task automatic seq_run(input int lo, input int hi);
    int n;
    int x0;
    n = 0;
    while (rst.mpu_reset_n && n < hi * XP) begin
      @(posedge clk);
      n++;
    end
    chk(32'(n >= lo * XP && !rst.mpu_reset_n), 32'h1);
    x0 = n_xtal;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (!rst.mpu_reset_n);
    chk(n, HALF_XTAL_CYC);
    while (!rst.hw_reset_n) @(posedge clk);
    // Signed distance from the documented restart count.
    x0 = n_xtal - x0 - RESTART_XTAL;
    chk(32'(x0 > -5 && x0 < 5), 32'h1);
    w(ADDR_REFRESH, 32'h1);
  endtask

  // Main sequence.
  initial begin
    logic [1:0]  r;
    logic [31:0] v;
    int          k;
    void'($urandom(32'hB05E));
    repeat (2) @(posedge clk);
    chk(32'(rst), 32'(RST_RESET));
    nrst <= 1'h1;
    rc(ADDR_STATUS, 32'h4, 32'h0);
    rc(ADDR_REFRESH, 32'hFFFFFFFF, 32'h0);
    v = $urandom & 32'h3;
    w(ADDR_INT_MASK, v);
    rc(ADDR_INT_MASK, 32'h3, v);
    wr(8'h40, 32'hFFFFFFFF, r);
    chk(32'(r), 32'(RESP_SLVERR));
    rd(8'h40, v, r);
    chk(32'(r), 32'(RESP_SLVERR));
    m_mask = 3;
    w(ADDR_INT_MASK, 32'h3);
    // Refresh writes, wake low and the emulator command hold off overflow.
    k = n_fall;
    repeat (8) begin
      w(ADDR_REFRESH, 32'h1);
      repeat ($urandom_range(LIM - 4, 1) * XP) @(posedge clk);
    end
    chk(n_fall, k);
    wake <= 1'h0;
    repeat (3 * LIM * XP) @(posedge clk);
    // While wake is low the count is held at zero.
    rc(ADDR_COUNT, 32'hFFFFFFFF, 32'h0);
    wake <= 1'h1;
    repeat (4) begin
      repeat ((LIM - 4) * XP) @(posedge clk);
      ice_cmd <= ICE_CMD_REFRESH;
      ice_cmd_valid <= 1'h1;
      @(posedge clk);
      ice_cmd_valid <= 1'h0;
    end
    chk(n_fall, k);
    // Overflow, flag survives the restart, firmware clears it.
    seq_run(LIM - 2, LIM + 3);
    m_flag = 1;
    m_int = 1;
    rc(ADDR_STATUS, 32'h4, 32'h4);
    rc(ADDR_INT_STAT, 32'h3, 32'(m_int));
    ck_irq();
    w(ADDR_INT_STAT, 32'h1);
    m_int = 0;
    ck_irq();
    w(ADDR_STATUS, 32'h4);
    m_flag = 0;
    rc(ADDR_STATUS, 32'h4, 32'h0);
    // A stopped crystal flags the fault and resets once it runs again.
    w(ADDR_REFRESH, 32'h1);
    k = n_fall;
    xrun <= 1'h0;
    repeat (3 * OSC) @(posedge clk);
    chk(n_fall, k);
    m_flag = 1;
    m_int = 2;
    rc(ADDR_STATUS, 32'h4, 32'h4);
    rc(ADDR_STATUS, 32'h8, 32'h8);
    ck_irq();
    xrun <= 1'h1;
    seq_run(0, 3);
    // Each source in turn: power fault, emulator reset, reset pin.
    for (int i = 0; i < 3; i++) begin
      {ext_low, emu_low, pf_below} <= 3'h1 << i;
      repeat (6) @(posedge clk);
      chk(32'(rst), (i == 1) ? 32'h0 : 32'h1);
      {ext_low, emu_low, pf_below} <= 3'h0;
      while (!rst.hw_reset_n) @(posedge clk);
      w(ADDR_REFRESH, 32'h1);
      if (i != 1) begin
        m_int = 0;
        m_mask = 0;
      end
      if (i == 2) m_flag = 0;
      rc(ADDR_STATUS, 32'h4, 32'(m_flag << 2));
      rc(ADDR_INT_STAT, 32'h3, 32'(m_int));
      rc(ADDR_INT_MASK, 32'h3, 32'(m_mask));
    end
    // Tie to the main supply inhibits watchdog and fault hold.
    k = n_fall;
    pf_tied <= 1'h1;
    pf_below <= 1'h1;
    repeat (3 * LIM * XP) @(posedge clk);
    chk(32'(rst), 32'h6);
    chk(n_fall, k);
    rc(ADDR_STATUS, 32'h20, 32'h20);
    end_of_test();
  end

  // Watchdog against a hung run; two restart waits of about 33,000 cycles
  // each dominate the expected length of about 70,000 cycles.
  initial begin
    repeat (90000) @(posedge clk);
    n_errors++;
    end_of_test();
  end
endmodule

// >>> dv/wdr_checker.sv
// Checker on the reset outputs and interrupt of the watchdog block.
module wdr_checker
  import wdr_pkg::*;
(
  input wire logic     clk,
  input wire logic     nrst,
  input wire wdr_src_t src,
  input wire wdr_rst_t rst,
  input wire logic     irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  logic [15:0] lo_r;
  logic        wd_r;
  // Times each processor reset and notes whether no source pin caused it.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lo_r <= 16'h0000;
      wd_r <= 1'h0;
    end else begin
      lo_r <= rst.mpu_reset_n ? 16'h0000 : lo_r + 16'h0001;
      if ($fell(rst.mpu_reset_n)) begin
        wd_r <= src.ext_reset_n_pin && src.emu_reset_n && !src.pf_below_bias;
      end
    end
  end
  sequence s_pin_low;
    !src.ext_reset_n_pin [*5];
  endsequence
  sequence s_fault;
    (src.pf_below_bias && !src.pf_tied_main) [*5];
  endsequence
  sequence s_wd_end;
    $rose(rst.mpu_reset_n) && wd_r;
  endsequence
  pin_hold_a: assert property (s_pin_low |-> rst.dig_hold)
    else $error("reset pin did not hold the logic");
  fault_hold_a: assert property (s_fault |-> rst.dig_hold)
    else $error("power fault did not hold the logic");
  tied_free_a: assert property (
    (src.ext_reset_n_pin && src.pf_tied_main) [*6] |-> !rst.dig_hold)
    else $error("hold raised while tied to supply");
  emu_reset_a: assert property (
    !src.emu_reset_n [*5] |-> !rst.mpu_reset_n && !rst.hw_reset_n)
    else $error("emulator reset not passed on");
  pulse_len_a: assert property (
    s_wd_end |-> lo_r == 16'(HALF_XTAL_CYC))
    else $error("processor reset pulse has wrong length");
  hold_after_a: assert property (s_wd_end |-> !rst.hw_reset_n)
    else $error("system released with the processor pulse");
  fall_both_a: assert property (
    $fell(rst.mpu_reset_n) |-> !rst.hw_reset_n)
    else $error("processor reset without system reset");
  irq_clear_a: assert property (rst.dig_hold [*4] |-> !irq)
    else $error("interrupt kept under hold");
  run_release_a: assert property (
    $rose(rst.hw_reset_n) |-> rst.mpu_reset_n)
    else $error("system released with processor held");
endmodule

bind wdr_watchdog wdr_checker u_chk (
  .clk  (clk),
  .nrst (nrst),
  .src  (src),
  .rst  (rst),
  .irq  (irq)
);

// >>> dv/wdr_src_model.sv
// Far-side model: crystal oscillator and the reset source pins.
module wdr_src_model
  import wdr_pkg::*;
#(
  parameter int unsigned HALF_NS = 20
) (
  input  wire logic xtal_run,
  input  wire logic ext_low,
  input  wire logic emu_low,
  input  wire logic pf_below,
  input  wire logic pf_tied,
  input  wire logic wake,
  output wdr_src_t  src
);
  timeunit 1ns;
  timeprecision 1ps;
  logic xtal_r;
  // A stopped crystal freezes at its last level, like a dead oscillator.
  initial begin
    xtal_r = 1'h0;
    forever begin
      #(HALF_NS);
      if (xtal_run) xtal_r = ~xtal_r;
    end
  end
  // Pin levels seen by the block; active-low pins are inverted here.
  assign src = {~ext_low, ~emu_low, pf_below, pf_tied,
                wake, xtal_r};
endmodule

// >>> hdl/wdr_pkg.sv
// Package with constants and types for the watchdog and reset controller.
package wdr_pkg;

  // Clock rates.
  localparam int unsigned CLK_HZ          = 200_000_000;
  localparam int unsigned XTAL_HZ         = 32_768;

  // Refresh interval in milliseconds and the crystal edges it spans.
  localparam int unsigned WDT_PERIOD_MS   = 1500;
  localparam int unsigned WDT_LIMIT_DEF   = WDT_PERIOD_MS * XTAL_HZ / 1000;

  // Processor reset pulse of half a crystal period, rounded down.
  localparam int unsigned HALF_XTAL_CYC   = CLK_HZ / (2 * XTAL_HZ);

  // Crystal edges from overflow until the system reset is released.
  localparam int unsigned RESTART_XTAL    = 4100;

  // Missing crystal periods that count as a stopped or slow oscillator.
  localparam int unsigned OSC_MISS_PER    = 4;
  localparam int unsigned OSC_TIMEOUT_DEF = OSC_MISS_PER * (CLK_HZ / XTAL_HZ);

  // Width of the post-overflow sequencing counters.
  localparam int unsigned SEQ_W           = 13;

  // Emulator command that restarts the watchdog.
  localparam logic [7:0]  ICE_CMD_REFRESH = 8'h14;

  // Register byte offsets.
  localparam logic [7:0]  ADDR_REFRESH    = 8'h00;
  localparam logic [7:0]  ADDR_STATUS     = 8'h04;
  localparam logic [7:0]  ADDR_INT_STAT   = 8'h08;
  localparam logic [7:0]  ADDR_INT_MASK   = 8'h0C;
  localparam logic [7:0]  ADDR_COUNT      = 8'h10;

  // Field positions.
  localparam int unsigned REFRESH_BIT     = 0;
  localparam int unsigned OVF_FLAG_BIT    = 2;
  localparam int unsigned OSC_FAIL_BIT    = 3;
  localparam int unsigned SEQ_BUSY_BIT    = 4;
  localparam int unsigned INHIBIT_BIT     = 5;
  localparam int unsigned INT_W           = 2;
  localparam int unsigned INT_OVF         = 0;
  localparam int unsigned INT_OSC         = 1;

  // AXI responses.
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

  // Watchdog sequencer states, Gray coded along run, hold, wait.
  typedef enum logic [1:0] {
    WD_RUN  = 2'h0,
    WD_HOLD = 2'h1,
    WD_WAIT = 2'h3,
    WD_OSC  = 2'h2
  } wdr_state_t;

  // Reset source and timing inputs.
  typedef struct packed {
    logic ext_reset_n_pin;
    logic emu_reset_n;
    logic pf_below_bias;
    logic pf_tied_main;
    logic wake;
    logic crystal_clock_32k;
  } wdr_src_t;

  // Reset outputs.
  typedef struct packed {
    logic hw_reset_n;
    logic mpu_reset_n;
    logic dig_hold;
  } wdr_rst_t;

  localparam wdr_src_t SRC_RESET = 6'h32;
  localparam wdr_rst_t RST_RESET = 3'h1;

endpackage

// >>> hdl/wdr_watchdog.sv
// Hardware watchdog, oscillator check and reset merge with AXI4-Lite access.
//
// Decided for this implementation: register access over AXI4-Lite and the address map.
module wdr_watchdog
  import wdr_pkg::*;
#(
  parameter int unsigned WDT_LIMIT   = WDT_LIMIT_DEF,
  parameter int unsigned OSC_TIMEOUT = OSC_TIMEOUT_DEF,
  parameter int unsigned ADDR_W      = 8
) (
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire wdr_src_t          src,
  input  wire logic              ice_cmd_valid,
  input  wire logic [7:0]        ice_cmd,
  output wdr_rst_t               rst,
  output logic                   irq
);

  localparam int unsigned CNT_W = $clog2(WDT_LIMIT + 1);
  localparam int unsigned OSC_W = $clog2(OSC_TIMEOUT + 1);
  localparam logic [CNT_W-1:0] WD_LAST   = CNT_W'(WDT_LIMIT - 1);
  localparam logic [OSC_W-1:0] OSC_LAST  = OSC_W'(OSC_TIMEOUT - 1);
  localparam logic [SEQ_W-1:0] HOLD_LAST = SEQ_W'(HALF_XTAL_CYC - 1);
  localparam logic [SEQ_W-1:0] REL_LAST  = SEQ_W'(RESTART_XTAL);

  wdr_src_t            sync1_r;
  wdr_src_t            sync2_r;
  logic                xtal_d_r;
  wdr_state_t          state_r;
  wdr_state_t          state_nxt;
  logic [CNT_W-1:0]    wd_cnt_r;
  logic [OSC_W-1:0]    osc_cnt_r;
  logic [SEQ_W-1:0]    hold_cnt_r;
  logic [SEQ_W-1:0]    rel_cnt_r;
  logic                ovf_flag_r;
  logic                osc_fail_r;
  logic [INT_W-1:0]    int_stat_r;
  logic [INT_W-1:0]    int_mask_r;
  logic [INT_W-1:0]    int_stat_nxt;
  logic                aw_full_r;
  logic                w_full_r;
  logic [ADDR_W-1:0]   awaddr_r;
  logic [31:0]         wdata_r;
  logic                wen_r;

  // Two-stage synchroniser on every source; only sync2_r is used further.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sync1_r  <= SRC_RESET;
      sync2_r  <= SRC_RESET;
      xtal_d_r <= 1'b0;
    end else begin
      sync1_r  <= src;
      sync2_r  <= sync1_r;
      xtal_d_r <= sync2_r.crystal_clock_32k;
    end
  end

  // Crystal edge and reset source decode.
  wire xtal_rise = sync2_r.crystal_clock_32k & ~xtal_d_r;
  wire inhibit   = sync2_r.pf_tied_main;
  wire pf_fault  = sync2_r.pf_below_bias & ~inhibit;
  wire ext_hold  = ~sync2_r.ext_reset_n_pin | pf_fault;
  wire emu_hold  = ~sync2_r.emu_reset_n;
  wire in_run    = (state_r == WD_RUN);
  wire in_hold   = (state_r == WD_HOLD);
  wire in_seq    = in_hold | (state_r == WD_WAIT);

  // Register write decode, gated while digital logic is held.
  wire wr_go     = aw_full_r & w_full_r & ~s_axi_bvalid;
  wire [7:0] wa  = 8'(awaddr_r);
  wire wr_ok     = (wa == ADDR_REFRESH) | (wa == ADDR_STATUS) |
                   (wa == ADDR_INT_STAT) | (wa == ADDR_INT_MASK) |
                   (wa == ADDR_COUNT);
  wire wr_eff    = wr_go & wen_r & ~ext_hold;
  wire wr_refr   = wr_eff & (wa == ADDR_REFRESH) & wdata_r[REFRESH_BIT];
  wire wr_stat   = wr_eff & (wa == ADDR_STATUS);
  wire wr_istat  = wr_eff & (wa == ADDR_INT_STAT);
  wire wr_imask  = wr_eff & (wa == ADDR_INT_MASK);

  // Restart sources for the watchdog count.
  wire ice_refr  = ice_cmd_valid & (ice_cmd == ICE_CMD_REFRESH);
  wire restart   = wr_refr | ~sync2_r.wake | ice_refr |
                   ext_hold | ~in_run | inhibit;

  // Overflow and oscillator check events; no register can mask these.
  wire ovf_evt   = in_run & xtal_rise & ~restart &
                   (wd_cnt_r == WD_LAST);
  wire osc_evt   = (state_r != WD_OSC) & ~inhibit & ~xtal_rise &
                   (osc_cnt_r == OSC_LAST);

  // Sequencer next state.
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      WD_RUN: begin
        if (ovf_evt) begin
          state_nxt = WD_HOLD;
        end
      end
      WD_HOLD: begin
        if (hold_cnt_r == HOLD_LAST) begin
          state_nxt = WD_WAIT;
        end
      end
      WD_WAIT: begin
        if (rel_cnt_r == REL_LAST) begin
          state_nxt = WD_RUN;
        end
      end
      WD_OSC: begin
        if (xtal_rise) begin
          state_nxt = WD_HOLD;
        end
      end
    endcase
    if (osc_evt) begin
      state_nxt = WD_OSC;
    end
    if (ext_hold) begin
      state_nxt = WD_RUN;
    end
  end

  // State register.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= WD_RUN;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Watchdog count of crystal edges.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wd_cnt_r <= '0;
    end else if (restart) begin
      wd_cnt_r <= '0;
    end else if (xtal_rise) begin
      wd_cnt_r <= (wd_cnt_r == WD_LAST) ? '0 : wd_cnt_r + 1'b1;
    end
  end

  // Clock cycles since the last crystal edge.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      osc_cnt_r <= '0;
    end else if (xtal_rise || osc_cnt_r == OSC_LAST) begin
      osc_cnt_r <= '0;
    end else begin
      osc_cnt_r <= osc_cnt_r + 1'b1;
    end
  end

  // Processor reset pulse length in clock cycles.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hold_cnt_r <= '0;
    end else if (!in_hold) begin
      hold_cnt_r <= '0;
    end else begin
      hold_cnt_r <= hold_cnt_r + 1'b1;
    end
  end

  // Crystal edges counted from the overflow to the release.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rel_cnt_r <= '0;
    end else if (!in_seq) begin
      rel_cnt_r <= '0;
    end else if (xtal_rise) begin
      rel_cnt_r <= rel_cnt_r + 1'b1;
    end
  end

  // Battery-backed overflow flag: only the pin or software clears it.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ovf_flag_r <= 1'b0;
    end else if (ovf_evt || osc_evt) begin
      ovf_flag_r <= 1'b1;
    end else if (!sync2_r.ext_reset_n_pin) begin
      ovf_flag_r <= 1'b0;
    end else if (wr_stat && wdata_r[OVF_FLAG_BIT]) begin
      ovf_flag_r <= 1'b0;
    end
  end

  // Oscillator failure indication, held until the crystal resumes.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      osc_fail_r <= 1'b0;
    end else begin
      osc_fail_r <= (state_nxt == WD_OSC);
    end
  end

  // Sticky interrupt status, set wins over the write-one clear.
  always_comb begin
    int_stat_nxt = int_stat_r;
    if (wr_istat) begin
      int_stat_nxt = int_stat_r & ~wdata_r[INT_W-1:0];
    end
    int_stat_nxt[INT_OVF] = int_stat_nxt[INT_OVF] | ovf_evt;
    int_stat_nxt[INT_OSC] = int_stat_nxt[INT_OSC] | osc_evt;
    if (ext_hold) begin
      int_stat_nxt = '0;
    end
  end

  // Interrupt status, mask and output.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      int_stat_r <= '0;
      int_mask_r <= '0;
      irq        <= 1'b0;
    end else begin
      int_stat_r <= int_stat_nxt;
      if (ext_hold) begin
        int_mask_r <= '0;
      end else if (wr_imask) begin
        int_mask_r <= wdata_r[INT_W-1:0];
      end
      irq <= |(int_stat_nxt & int_mask_r);
    end
  end

  // Merged reset outputs.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst <= RST_RESET;
    end else begin
      rst.hw_reset_n  <= ~(ext_hold | emu_hold |
                           (state_nxt == WD_HOLD) |
                           (state_nxt == WD_WAIT));
      rst.mpu_reset_n <= ~(ext_hold | emu_hold |
                           (state_nxt == WD_HOLD));
      rst.dig_hold    <= ext_hold;
    end
  end

  // Write address and data capture, taken in either order.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      aw_full_r <= 1'b0;
      w_full_r  <= 1'b0;
      awaddr_r  <= '0;
      wdata_r   <= '0;
      wen_r     <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_full_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wen_r    <= s_axi_wstrb[0];
      end else if (wr_go) begin
        w_full_r <= 1'b0;
      end
    end
  end

  // Write ready and response channel.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      s_axi_awready <= ~aw_full_r & ~(s_axi_awvalid & s_axi_awready) &
                       ~s_axi_bvalid;
      s_axi_wready  <= ~w_full_r & ~(s_axi_wvalid & s_axi_wready) &
                       ~s_axi_bvalid;
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read decode.
  wire [7:0] ra = 8'(s_axi_araddr);
  logic [31:0] rd_word;
  logic        rd_ok;
  always_comb begin
    rd_word = '0;
    rd_ok   = 1'b1;
    unique case (ra)
      ADDR_REFRESH:  rd_word = '0;
      ADDR_STATUS: begin
        rd_word[OVF_FLAG_BIT] = ovf_flag_r;
        rd_word[OSC_FAIL_BIT] = osc_fail_r;
        rd_word[SEQ_BUSY_BIT] = in_seq;
        rd_word[INHIBIT_BIT]  = inhibit;
      end
      ADDR_INT_STAT: rd_word[INT_W-1:0] = int_stat_r;
      ADDR_INT_MASK: rd_word[INT_W-1:0] = int_mask_r;
      ADDR_COUNT:    rd_word[CNT_W-1:0] = wd_cnt_r;
      default:       rd_ok = 1'b0;
    endcase
  end

  // Read address and data channels.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule
